/* utsm_serial_mux.sv */
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// Transceiver serial mode multiplexer
// ************************************************************
module utsm_serial_mux (
   input wire logic i_sys_clk, // 200 MHz clock
   input wire logic i_resetn, // Sync reset, active low
   input wire utsm_pkg::utsm_mode_t i_mode, // Wiring mode setting
   input wire logic i_port_active, // Port in use, mode locked
   input wire logic i_tx_en, // Controller wants to transmit
   input wire logic i_tx_dat_plus, // Tx data or plus value
   input wire logic i_tx_se0_minus, // Tx se0 request or minus
   input wire logic i_dat_plus_in, // Data/plus pin input
   input wire logic i_se0_minus_in, // Se0/minus pin input
   input wire logic i_rx_plus_buffered, // Dedicated plus input
   input wire logic i_rx_minus_buffered, // Dedicated minus input
   input wire logic i_rx_differential, // Dedicated diff input
   output logic o_tx_output_enable_n, // Transmit enable, low=tx
   output logic o_dat_plus_out, // Data/plus pin drive
   output logic o_dat_plus_oe, // Data/plus pin enable
   output logic o_se0_minus_out, // Se0/minus pin drive
   output logic o_se0_minus_oe, // Se0/minus pin enable
   output utsm_pkg::utsm_mode_t o_mode, // Mode in force
   output logic o_rx_dat_plus, // Rx data or plus line
   output logic o_rx_se0_minus, // Rx se0 flag or minus line
   output logic o_rx_differential // Rx differential data
);
   import utsm_pkg::*;

   utsm_mode_t mode;
   utsm_mode_t next_mode;
   logic [4:0] pins_sync;
   logic pin_dp;
   logic pin_sm;
   logic pin_vp1;
   logic pin_vm1;
   logic pin_rcv;
   logic next_oe_n;
   logic bidir;
   logic dse0;
   logic rx_phase;
   logic next_rx_a;
   logic next_rx_b;
   logic next_rx_c;

   // ************************************************************
   // Pin input synchronisers
   // ************************************************************
   utsm_sync #(.W(5)) u_sync (
      .i_sys_clk(i_sys_clk),
      .i_resetn(i_resetn),
      .i_async({i_dat_plus_in, i_se0_minus_in, i_rx_plus_buffered,
                i_rx_minus_buffered, i_rx_differential}),
      .o_sync(pins_sync)
   );

   utsm_rx_if rx_bus ();
   assign {pin_dp, pin_sm, pin_vp1, pin_vm1, pin_rcv} = pins_sync;

   // ************************************************************
   // Mode decode
   // ************************************************************
   // mode lock: changes only while port idle
   assign next_mode = i_port_active ? mode : i_mode;
   assign bidir = (mode == UTSM_DSE0_BIDIR) || (mode == UTSM_PM_BIDIR);
   assign dse0 = (mode == UTSM_DSE0_BIDIR) || (mode == UTSM_DSE0_UNIDIR);
   assign next_oe_n = ~i_tx_en;
   // Receiving once the enable has gone back high
   assign rx_phase = o_tx_output_enable_n;

   // ************************************************************
   // Receive source selection
   // ************************************************************
   // shared pins when bidirectional, except the 4-wire diff from the dedicated input
   always_comb begin
      next_rx_a = 1'h0;
      next_rx_b = 1'h0;
      next_rx_c = 1'h0;
      case (mode)
         UTSM_DSE0_BIDIR: begin
            next_rx_a = pin_dp;
            next_rx_b = pin_sm;
            next_rx_c = pin_dp;
         end
         UTSM_DSE0_UNIDIR: begin
            next_rx_a = pin_vp1;
            next_rx_b = pin_vm1;
            next_rx_c = pin_rcv;
         end
         UTSM_PM_BIDIR: begin
            next_rx_a = pin_dp;
            next_rx_b = pin_sm;
            next_rx_c = pin_rcv;
         end
         UTSM_PM_UNIDIR: begin
            next_rx_a = pin_vp1;
            next_rx_b = pin_vm1;
            next_rx_c = pin_rcv;
         end
         default: begin
            next_rx_a = 1'h0;
            next_rx_b = 1'h0;
            next_rx_c = 1'h0;
         end
      endcase
   end

   assign rx_bus.plus = next_rx_a;
   assign rx_bus.minus = next_rx_b;
   assign rx_bus.diff = next_rx_c;

   // ************************************************************
   // Mode and enable registers
   // ************************************************************
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         mode <= UTSM_MODE_RST;
         o_mode <= UTSM_MODE_RST;
         o_tx_output_enable_n <= UTSM_TXOE_N_RST;
      end else begin
         mode <= next_mode;
         o_mode <= next_mode;
         o_tx_output_enable_n <= next_oe_n;
      end
   end

   // ************************************************************
   // Transmit pin drive
   // ************************************************************
   // Outputs move with the enable so pins fight the transceiver only in the cycle after a unidirectional-to-bidirectional mode change
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         o_dat_plus_out <= 1'h0;
         o_se0_minus_out <= 1'h0;
         o_dat_plus_oe <= 1'h0;
         o_se0_minus_oe <= 1'h0;
      end else begin
         o_dat_plus_out <= i_tx_en & i_tx_dat_plus;
         o_se0_minus_out <= i_tx_en & i_tx_se0_minus;
         o_dat_plus_oe <= i_tx_en | ~bidir;
         o_se0_minus_oe <= i_tx_en | ~bidir;
      end
   end

   // ************************************************************
   // Receive sample registers
   // ************************************************************
   // Held at idle levels while transmitting; avoids echoing our drive
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         o_rx_dat_plus <= 1'h0;
         o_rx_se0_minus <= 1'h0;
         o_rx_differential <= 1'h0;
      end else if (rx_phase) begin
         o_rx_dat_plus <= rx_bus.plus;
         o_rx_se0_minus <= rx_bus.minus;
         o_rx_differential <= dse0 ? rx_bus.diff : rx_bus.diff;
      end else begin
         o_rx_dat_plus <= 1'h0;
         o_rx_se0_minus <= 1'h0;
         o_rx_differential <= 1'h0;
      end
   end
endmodule : utsm_serial_mux
`default_nettype wire

/* utsm_pkg.sv */
// Contract
// - Four selectable transceiver wiring modes supported
// - Transmit enable output is active low
// - 3-wire: data pin tx out, rx in
// - 3-wire: second pin drives/samples single-ended zero
// - 6-wire data mode: data, se0 pins output-only
// - 6-wire data mode: receive from dedicated inputs
// - 4-wire: first pin tx plus, rx plus
// - 4-wire: second pin tx/rx minus, plus rcv
// - 6-wire plus/minus: outputs tx, inputs receive
package utsm_pkg;
   // ************************************************************
   // Wiring modes
   // ************************************************************
   typedef enum logic [1:0] {
      UTSM_DSE0_BIDIR,
      UTSM_DSE0_UNIDIR,
      UTSM_PM_BIDIR,
      UTSM_PM_UNIDIR
   } utsm_mode_t;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam utsm_mode_t UTSM_MODE_RST = UTSM_DSE0_BIDIR;
   localparam logic UTSM_TXOE_N_RST = 1'h1;
   localparam int UTSM_SYNC_STAGES = 2;
endpackage : utsm_pkg

/* utsm_rx_if.sv */
`timescale 1ns/100ps
`default_nettype none
// Receive line bundle between the sampler and the top
interface utsm_rx_if;
   logic plus;
   logic minus;
   logic diff;
   modport src (output plus, output minus, output diff);
   modport dst (input plus, input minus, input diff);
endinterface : utsm_rx_if
`default_nettype wire

/* utsm_sync.sv */
`timescale 1ns/100ps
`default_nettype none
// Two-flop synchroniser for pin inputs
module utsm_sync #(
   parameter int W = 1
) (
   input wire logic i_sys_clk, // System clock
   input wire logic i_resetn, // Sync reset, active low
   input wire logic [W-1:0] i_async, // Raw pin level
   output logic [W-1:0] o_sync // Synchronised level
);
   logic [W-1:0] meta;

   // First stage read only by second stage
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         meta <= '0;
         o_sync <= '0;
      end else begin
         meta <= i_async;
         o_sync <= meta;
      end
   end
endmodule : utsm_sync
`default_nettype wire

/* utsm_xcvr.sv */
`timescale 1ns/100ps
`default_nettype none
// Line transceiver model facing the mux pins
module utsm_xcvr (
   input wire utsm_pkg::utsm_mode_t i_mode, // Mode in force
   input wire logic i_txoe_n, // Enable, low = device sends
   input wire logic i_dp, i_dp_oe, i_sm, i_sm_oe, // Device pin drive
   input wire logic [2:0] i_line, // Cable plus, minus, diff
   output logic o_dp, o_sm, // Shared pin levels
   output logic [2:0] o_ded // Dedicated plus, minus, diff
);
   import utsm_pkg::*;
   wire logic drv = i_txoe_n && !i_mode[0];
   wire logic se0 = !i_line[2] && !i_line[1];
   // Undriven pins flip, so a stale level never passes
   assign o_dp = i_dp_oe ? i_dp : drv ? i_line[2] : !i_dp;
   assign o_sm = i_sm_oe ? i_sm : !drv ? !i_sm : i_mode[1] ? i_line[1] : se0;
   assign o_ded = i_line;
endmodule : utsm_xcvr
`default_nettype wire

/* utsm_props.sv */
`timescale 1ns/100ps
`default_nettype none
// Port-level checks for the serial mux
module utsm_props
   import utsm_pkg::*;
(
   input wire logic i_sys_clk, i_resetn, i_port_active, i_tx_en,
   input wire utsm_pkg::utsm_mode_t i_mode, o_mode,
   input wire logic i_tx_dat_plus, i_tx_se0_minus, i_dat_plus_in,
   input wire logic i_se0_minus_in, i_rx_plus_buffered, i_rx_differential,
   input wire logic i_rx_minus_buffered, o_tx_output_enable_n,
   input wire logic o_dat_plus_out, o_dat_plus_oe, o_se0_minus_out,
   input wire logic o_rx_dat_plus, o_rx_se0_minus, o_rx_differential
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);
   logic rdy, en, dp, sm;
   // Receive outputs and their sources per wiring
   wire logic [2:0] rx = {o_rx_dat_plus, o_rx_se0_minus, o_rx_differential};
   wire logic [2:0] ded = {i_rx_plus_buffered, i_rx_minus_buffered,
      i_rx_differential};
   wire logic [2:0] pinb = {i_dat_plus_in, i_se0_minus_in, i_dat_plus_in};
   wire logic [2:0] pinp = {i_dat_plus_in, i_se0_minus_in, i_rx_differential};
   // Request one edge back; rdy masks the edge after reset
   always_ff @(posedge i_sys_clk) begin
      rdy <= i_resetn;
      {en, dp, sm} <= {i_tx_en, i_tx_dat_plus, i_tx_se0_minus};
   end
   sequence s_idle(sel);
      (o_tx_output_enable_n && sel && rdy) [*4];
   endsequence
   AST_TXOE: assert property (rdy |-> o_tx_output_enable_n == !en)
      else $error("enable level wrong");
   AST_DRIVE: assert property (rdy |->
      {o_dat_plus_out, o_se0_minus_out} == (en ? {dp, sm} : 2'h0))
      else $error("pin drive wrong");
   AST_OE: assert property (rdy && $stable(o_mode) &&
      $past(i_mode) == o_mode |-> o_dat_plus_oe == (en || o_mode[0]))
      else $error("pin enable wrong");
   AST_MODE: assert property (rdy && !$past(i_port_active) |->
      o_mode == $past(i_mode)) else $error("mode not taken");
   AST_LOCK: assert property (rdy && $past(i_port_active) |->
      $stable(o_mode)) else $error("mode moved while locked");
   AST_QUIET: assert property (
      !o_tx_output_enable_n [*2] |-> rx == 3'h0) else $error("rx not quiet");
   AST_RXU: assert property (
      s_idle(o_mode[0]) |-> rx == $past(ded, 3)) else $error("rx uni wrong");
   AST_RXD: assert property (
      s_idle(o_mode == UTSM_DSE0_BIDIR) |-> rx == $past(pinb, 3))
      else $error("rx dse0 wrong");
   AST_RXP: assert property (
      s_idle(o_mode == UTSM_PM_BIDIR) |-> rx == $past(pinp, 3))
      else $error("rx pm wrong");
endmodule : utsm_props
bind utsm_serial_mux utsm_props u_props (.*);
`default_nettype wire

/* usb_transceiver_serial_mode_mux_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module usb_transceiver_serial_mode_mux_tb_top;
   import utsm_pkg::*;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic act = 1'h0;
   logic tx_en = 1'h0;
   logic [1:0] tx = 2'h0;
   logic [2:0] line = 3'h4;
   utsm_mode_t mode = UTSM_DSE0_BIDIR;
   wire utsm_mode_t o_mode;
   wire logic [2:0] ded, rx;
   wire logic txoe_n, dp, dp_oe, sm, sm_oe, dp_pin, sm_pin;
   int bad_count = 0;
   int checks = 0;
   int cyc = 0;
   always #2.5 clk = ~clk;
   utsm_serial_mux u_dut (.i_sys_clk(clk), .i_resetn(rst_n), .i_mode(mode),
      .i_port_active(act), .i_tx_en(tx_en), .i_tx_dat_plus(tx[1]),
      .i_tx_se0_minus(tx[0]), .i_dat_plus_in(dp_pin),
      .i_se0_minus_in(sm_pin), .i_rx_plus_buffered(ded[2]),
      .i_rx_minus_buffered(ded[1]), .i_rx_differential(ded[0]),
      .o_tx_output_enable_n(txoe_n), .o_dat_plus_out(dp),
      .o_dat_plus_oe(dp_oe), .o_se0_minus_out(sm), .o_se0_minus_oe(sm_oe),
      .o_mode(o_mode), .o_rx_dat_plus(rx[2]), .o_rx_se0_minus(rx[1]),
      .o_rx_differential(rx[0]));
   utsm_xcvr u_xcvr (.i_mode(o_mode), .i_txoe_n(txoe_n), .i_dp(dp),
      .i_dp_oe(dp_oe), .i_sm(sm), .i_sm_oe(sm_oe), .i_line(line),
      .o_dp(dp_pin), .o_sm(sm_pin), .o_ded(ded));
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : finish_test
   // Watchdog; the run needs about 175 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         bad_count++;
         finish_test();
      end
   end
   task automatic chk(input logic [4:0] got, input logic [4:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick
   task automatic mode_set(input utsm_mode_t m);
      act = 1'h0;
      mode = m;
      tick(2);
      act = 1'h1;
      chk(o_mode, m);
   endtask : mode_set
   // Locked port must ignore a new mode
   task automatic lock_check();
      mode = UTSM_PM_UNIDIR;
      tick(3);
      chk(o_mode, UTSM_DSE0_BIDIR);
   endtask : lock_check
   task automatic tx_check(input utsm_mode_t m);
      line = 3'h6;
      tx_en = 1'h1;
      tx = 2'h2;
      tick(1);
      chk({txoe_n, dp, dp_oe, sm, sm_oe}, 5'h0d);
      tx = 2'h1;
      tick(1);
      chk({txoe_n, dp, sm, dp_pin, sm_pin}, 5'h05);
      tick(3);
      chk(rx, 5'h00);
      tx_en = 1'h0;
      tick(1);
      chk({txoe_n, dp, dp_oe, sm, sm_oe}, {2'h2, m[0], 1'h0, m[0]});
   endtask : tx_check
   // Mid-run reset while sending; mode falls back and stays locked
   task automatic reset_check();
      tx_en = 1'h1;
      tx = 2'h3;
      rst_n = 1'h0;
      tick(2);
      chk({txoe_n, dp, dp_oe, sm, sm_oe}, 5'h10);
      chk({o_mode, rx}, 5'h00);
      rst_n = 1'h1;
      tx_en = 1'h0;
      tick(2);
      chk(o_mode, UTSM_MODE_RST);
   endtask : reset_check
   // Every line state; only the 3-wire mode folds se0 and data
   task automatic rx_check(input utsm_mode_t m);
      logic [2:0] w;
      for (int k = 0; k < 8; k++) begin
         line = 3'(k);
         w = m == UTSM_DSE0_BIDIR ? {line[2], !line[2:1], line[2]} : line;
         tick(4);
         chk(rx, w);
      end
   endtask : rx_check
   initial begin
      tick(5);
      rst_n = 1'h1;
      mode_set(UTSM_DSE0_BIDIR);
      lock_check();
      for (int m = 0; m < 4; m++) begin
         mode_set(utsm_mode_t'(m));
         tx_check(utsm_mode_t'(m));
         rx_check(utsm_mode_t'(m));
      end
      reset_check();
      finish_test();
   end
endmodule : usb_transceiver_serial_mode_mux_tb_top
`default_nettype wire
